// ### inc/ssw_defs.svh
// Constants for the supply supervisor and watchdog block.
// Assumes a 200 MHz core clock; included by bare name.
//
// Operation
// R1: Main supply below threshold asserts both reset outputs.
// R2: After supply recovers, reset releases only after 200 ms delay.
// R3: Active-low reset pin forced low externally starts and holds a reset.
// R4: Watchdog variant restarts its timer on every kick input edge.
// R5: Watchdog variant asserts reset if no kick edge within 1.6 s.
// R6: Auxiliary low flag is low while aux sense below 1.25 V reference.
// R7: Memory write inhibit asserted while main supply below threshold.
// R8: Active-high reset exists only in the variant without watchdog.
// R9: Host toggles kick input more often than every 1.6 s.
// R10: Manual or watchdog reset also gets release delay; watchdog restarts on release.
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

`define SSW_CLK_PERIOD_PS 5000
`define SSW_RELEASE_DELAY_MS 200
`define SSW_WDOG_TIMEOUT_MS 1600
`define SSW_RELEASE_CYCLES ((`SSW_RELEASE_DELAY_MS * 64'd1000000000) / `SSW_CLK_PERIOD_PS)
`define SSW_WDOG_CYCLES ((`SSW_WDOG_TIMEOUT_MS * 64'd1000000000) / `SSW_CLK_PERIOD_PS)
`define SSW_CNT_W 32

`endif

// ### inc/ssw_pkg.sv
// Types shared by the supply supervisor and watchdog block.
// Assumes no other package is needed.
package ssw_pkg;

  typedef enum logic [1:0] {
    SSW_HOLD,
    SSW_DELAY,
    SSW_RUN,
    SSW_MANUAL
  } ssw_state_t;

  // Synchronised sense inputs
  typedef struct packed {
    logic main_low;
    logic aux_low;
    logic pin_low;
    logic kick;
  } ssw_sense_t;

endpackage : ssw_pkg

// ### logic/ssw_sync.sv
// Two-flop synchroniser bank for the pin inputs.
// Assumes all inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module ssw_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Each bit resets to its own bit of RESET_VAL
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_reg[i] <= RESET_VAL[i];
        sync_reg[i] <= RESET_VAL[i];
      end else begin
        meta_reg[i] <= meta_next[i];
        sync_reg[i] <= sync_next[i];
      end
    end
  end

  assign sync_out = sync_reg;

endmodule : ssw_sync

`default_nettype wire

// ### logic/ssw_top.sv
// Supervisory reset logic: supply, manual and watchdog reset with release delay.
// Assumes comparator outputs and pins are asynchronous; counts may be shortened.
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.svh"

module ssw_top #(
  parameter bit WDOG_VARIANT = 1'b0,
  parameter logic [31:0] RELEASE_CYCLES = 32'(`SSW_RELEASE_CYCLES),
  parameter logic [31:0] WDOG_CYCLES = 32'(`SSW_WDOG_CYCLES)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic main_below_thr,
  input wire logic aux_below_ref,
  input wire logic reset_n_pin_in,
  input wire logic watchdog_kick_input,
  output logic reset_hi_out,
  output logic reset_hi_oe_n,
  output logic reset_n_out,
  output logic reset_n_oe_n,
  output logic aux_low_flag,
  output logic mem_write_inhibit
);

  // ==========================================================
  // Input synchronisation
  ssw_pkg::ssw_sense_t sense;
  logic [3:0] sense_vec;

  ssw_sync #(
    .W(4),
    .RESET_VAL(4'hD)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({main_below_thr, aux_below_ref, reset_n_pin_in, watchdog_kick_input}),
    .sync_out(sense_vec)
  );

  // Pin bit flips after the flops so that it reads as a low request
  assign sense = ssw_pkg::ssw_sense_t'(sense_vec ^ 4'h2);

  // ==========================================================
  // Kick edge detection and watchdog timer
  logic kick_d_reg;
  logic kick_d_next;
  logic kick_edge;
  logic [`SSW_CNT_W-1:0] wdog_cnt_reg;
  logic [`SSW_CNT_W-1:0] wdog_cnt_next;
  logic wdog_expire;
  ssw_pkg::ssw_state_t state_reg;
  ssw_pkg::ssw_state_t state_next;

  assign kick_edge = sense.kick ^ kick_d_reg;
  // A kick on the last cycle still restarts the timer
  assign wdog_expire = WDOG_VARIANT && (state_reg == ssw_pkg::SSW_RUN) && !kick_edge &&
                       (wdog_cnt_reg >= WDOG_CYCLES - 32'h1);

  always_comb begin
    kick_d_next = sense.kick;
    wdog_cnt_next = wdog_cnt_reg;
    if (state_reg != ssw_pkg::SSW_RUN || kick_edge) begin
      wdog_cnt_next = '0; // [R4] [R10]
    end else if (!wdog_expire) begin
      wdog_cnt_next = wdog_cnt_reg + 32'h1; // [R5]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      kick_d_reg <= 1'b1;
      wdog_cnt_reg <= '0;
    end else begin
      kick_d_reg <= kick_d_next;
      wdog_cnt_reg <= wdog_cnt_next;
    end
  end

  // ==========================================================
  // Reset sequencer
  logic [`SSW_CNT_W-1:0] dly_cnt_reg;
  logic [`SSW_CNT_W-1:0] dly_cnt_next;
  logic hold_cause;
  logic ext_low;
  logic [1:0] oe_hist_reg;
  logic [1:0] oe_hist_next;

  // Own drive delayed by the synchroniser depth, so that a synced low we caused is masked
  always_comb begin
    oe_hist_next = {oe_hist_reg[0], reset_n_oe_n};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_hist_reg <= 2'h0;
    end else begin
      oe_hist_reg <= oe_hist_next;
    end
  end

  // Only an outside low counts as a manual request
  assign ext_low = sense.pin_low && oe_hist_reg[1];
  assign hold_cause = sense.main_low || ext_low;

  always_comb begin
    state_next = state_reg;
    dly_cnt_next = dly_cnt_reg;
    case (state_reg)
      ssw_pkg::SSW_HOLD: begin
        dly_cnt_next = '0;
        if (!sense.main_low) begin
          state_next = ssw_pkg::SSW_DELAY; // [R2]
        end
      end
      // Line left to the outside driver, so that its release can be seen
      ssw_pkg::SSW_MANUAL: begin
        dly_cnt_next = '0;
        if (sense.main_low) begin
          state_next = ssw_pkg::SSW_HOLD; // [R1]
        end else if (!sense.pin_low) begin
          state_next = ssw_pkg::SSW_DELAY; // [R3] [R10]
        end
      end
      ssw_pkg::SSW_DELAY: begin
        if (sense.main_low) begin
          state_next = ssw_pkg::SSW_HOLD; // [R1]
        end else if (dly_cnt_reg >= RELEASE_CYCLES - 32'h1) begin
          state_next = ssw_pkg::SSW_RUN; // [R2]
        end else begin
          dly_cnt_next = dly_cnt_reg + 32'h1;
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (sense.main_low) begin
          state_next = ssw_pkg::SSW_HOLD; // [R1]
        end else if (ext_low) begin
          state_next = ssw_pkg::SSW_MANUAL; // [R3]
        end else if (wdog_expire) begin
          state_next = ssw_pkg::SSW_DELAY; // [R5] [R10]
        end
        dly_cnt_next = '0;
      end
      default: begin
        state_next = ssw_pkg::SSW_HOLD;
        dly_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ssw_pkg::SSW_HOLD;
      dly_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      dly_cnt_reg <= dly_cnt_next;
    end
  end

  // ==========================================================
  // Output registers
  logic in_reset;
  logic reset_hi_oe_n_next;
  logic reset_n_oe_n_next;
  logic aux_low_flag_next;
  logic inhibit_next;

  assign in_reset = (state_next != ssw_pkg::SSW_RUN);

  // In a manual hold the outside low keeps the line asserted; when it lets go the
  // line stands high for the synchroniser latency before the release delay drives it
  always_comb begin
    reset_n_oe_n_next = !in_reset || (state_next == ssw_pkg::SSW_MANUAL); // [R1] [R3]
    reset_hi_oe_n_next = !(in_reset && !WDOG_VARIANT); // [R1] [R8]
    aux_low_flag_next = !sense.aux_low; // [R6]
    inhibit_next = sense.main_low; // [R7]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_n_oe_n <= 1'b0;
      reset_hi_oe_n <= WDOG_VARIANT; // [R8]
      aux_low_flag <= 1'b0;
      mem_write_inhibit <= 1'b1;
      reset_hi_out <= 1'b1;
      reset_n_out <= 1'b0;
    end else begin
      reset_n_oe_n <= reset_n_oe_n_next;
      reset_hi_oe_n <= reset_hi_oe_n_next;
      aux_low_flag <= aux_low_flag_next;
      mem_write_inhibit <= inhibit_next;
      reset_hi_out <= 1'b1;
      reset_n_out <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence main_drop_s;
    sense.main_low;
  endsequence

  sequence reset_driven_s;
    !reset_n_oe_n && (WDOG_VARIANT || !reset_hi_oe_n);
  endsequence

  supply_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    main_drop_s |=> reset_driven_s) else $error("reset not driven on low supply"); // [R1]

  release_delay_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ssw_pkg::SSW_HOLD && !sense.main_low) |=> !reset_n_oe_n [*2])
    else $error("reset released before delay"); // [R2]

  release_time_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(reset_n_oe_n) |-> $past(dly_cnt_reg) == RELEASE_CYCLES - 32'h1)
    else $error("release delay count wrong"); // [R2]

  manual_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ssw_pkg::SSW_MANUAL && sense.pin_low && !sense.main_low) |=> state_reg == ssw_pkg::SSW_MANUAL)
    else $error("manual reset not held"); // [R3]

  kick_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    (kick_edge && state_reg == ssw_pkg::SSW_RUN) |=> wdog_cnt_reg == '0)
    else $error("kick did not restart watchdog"); // [R4]

  wdog_fire_a: assert property (@(posedge clk) disable iff (!rstn)
    (wdog_expire && !hold_cause) |=> state_reg == ssw_pkg::SSW_DELAY ##1 !reset_n_oe_n)
    else $error("watchdog did not reset"); // [R5]

  aux_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> aux_low_flag == !$past(sense.aux_low)) else $error("aux flag wrong"); // [R6]

  write_inhibit_a: assert property (@(posedge clk) disable iff (!rstn)
    sense.main_low |=> mem_write_inhibit) else $error("write not inhibited"); // [R7]

  variant_hi_a: assert property (@(posedge clk) disable iff (!rstn)
    WDOG_VARIANT |-> reset_hi_oe_n) else $error("active-high reset driven in watchdog variant"); // [R8]

endmodule : ssw_top

`default_nettype wire

// ### testbench/ssw_host_model.sv
// Host model: kicks the watchdog and presses manual reset.
// Assumes an open-drain reset pin with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model #(
  parameter int GAP = 30
) (
  input wire logic clk,
  input wire logic kick_en,
  input wire logic press,
  input wire logic oe_n,
  output logic kick,
  output logic pin
);
  int cnt = 0;
  initial kick = 1'b0;
  // Pull-up unless either side pulls low
  assign pin = oe_n & ~press;
  always @(posedge clk) begin
    cnt <= (cnt + 1) % GAP;
    if (kick_en && cnt == 0) kick <= #1 ~kick;
  end
endmodule : ssw_host_model
`default_nettype wire

// ### testbench/testbench.sv
// Bench for both variants of the supervisor with host models.
// Assumes short release and watchdog counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int RC = 20;
  localparam int WC = 100;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic main_low = 1'b1;
  logic aux_low = 1'b0;
  logic press = 1'b0;
  logic kick_en = 1'b1;
  logic pin0, pin1, kick0, kick1;
  logic hi_oe0, rn_oe0, aux0, inh0, hi_oe1, rn_oe1;
  logic hi0, rn0, hi1, rn1, aux1, inh1;
  int errors = 0;
  int n_tests = 0;
  int i;
  always #2.5 clk = ~clk;
  ssw_top #(.WDOG_VARIANT(1'b0), .RELEASE_CYCLES(32'(RC)), .WDOG_CYCLES(32'(WC))) u_dut (
    .clk(clk), .rstn(rstn), .main_below_thr(main_low), .aux_below_ref(aux_low),
    .reset_n_pin_in(pin0), .watchdog_kick_input(kick0), .reset_hi_out(hi0), .reset_hi_oe_n(hi_oe0),
    .reset_n_out(rn0), .reset_n_oe_n(rn_oe0), .aux_low_flag(aux0), .mem_write_inhibit(inh0));
  ssw_top #(.WDOG_VARIANT(1'b1), .RELEASE_CYCLES(32'(RC)), .WDOG_CYCLES(32'(WC))) u_wd (
    .clk(clk), .rstn(rstn), .main_below_thr(main_low), .aux_below_ref(aux_low),
    .reset_n_pin_in(pin1), .watchdog_kick_input(kick1), .reset_hi_out(hi1), .reset_hi_oe_n(hi_oe1),
    .reset_n_out(rn1), .reset_n_oe_n(rn_oe1), .aux_low_flag(aux1), .mem_write_inhibit(inh1));
  ssw_host_model h0 (.clk(clk), .kick_en(kick_en), .press(press), .oe_n(rn_oe0), .kick(kick0), .pin(pin0));
  ssw_host_model h1 (.clk(clk), .kick_en(kick_en), .press(1'b0), .oe_n(rn_oe1), .kick(kick1), .pin(pin1));
  // ==========
  // Helpers
  task automatic chk(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task automatic print_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'hef5b50c7));
    cy(1);
    chk(rn_oe0, 1'b0);
    chk(inh0, 1'b1);
    chk(hi_oe1, 1'b1);
    cy(1);
    rstn = 1'b1;
    cy(10);
    chk(hi_oe0, 1'b0);
    chk(rn_oe0, 1'b0);
    chk(inh0, 1'b1);
    main_low = 1'b0;
    cy(RC - 2);
    chk(rn_oe0, 1'b0);
    chk(inh0, 1'b0);
    cy(8);
    chk(rn_oe0, 1'b1);
    chk(hi_oe0, 1'b1);
    chk(hi_oe1, 1'b1);
    chk(hi0, 1'b1);
    chk(rn0, 1'b0);
    chk(rn1, 1'b0);
    chk(hi1, 1'b1);
    chk(inh1, 1'b0);
    for (i = 0; i < 8; i++) begin
      aux_low = 1'($urandom);
      cy(5);
      chk(aux0, ~aux_low);
      chk(aux1, ~aux_low);
    end
    press = 1'b1;
    cy(RC + 10);
    chk(pin0, 1'b0);
    chk(hi_oe0, 1'b0);
    press = 1'b0;
    cy(RC - 2);
    chk(rn_oe0, 1'b0);
    cy(8);
    chk(rn_oe0, 1'b1);
    for (i = 0; i < 4 * WC; i++) begin
      cy(1);
      chk(rn_oe1, 1'b1);
    end
    // Stop kicking right after an edge so the timeout is measured from it
    @(kick1);
    kick_en = 1'b0;
    cy(WC - 5);
    chk(rn_oe1, 1'b1);
    cy(13);
    chk(rn_oe1, 1'b0);
    chk(hi_oe1, 1'b1);
    kick_en = 1'b1;
    cy(RC + 6);
    chk(rn_oe1, 1'b1);
    main_low = 1'b1;
    cy(5);
    chk(hi_oe0, 1'b0);
    chk(inh0, 1'b1);
    chk(inh1, 1'b1);
    print_verdict();
  end
  initial begin
    #(5 * 4000);
    errors++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
